// *** srep_assertions.sv ***
// Purpose: link and status checks
// Assumes: host end makes sclk
// Notes: busy/wel come from the device end
`timescale 1ns/10ps
module srep_assertions #(
  parameter int ERASE_CYC = 20,
  parameter int PROG_CYC  = 600
) (
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic sdi,
  input wire logic sdo,
  input wire logic busy_out,
  input wire logic write_enable_latch_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (srst_in);
  int unsigned cnt_r;
  always_ff @(posedge clk_in) cnt_r <= busy_out ? cnt_r + 1 : 0;
  // ====
  // checks
  a_sclk_idle_low: assert property (cs_n |-> !sclk)
    else $error("sclk high outside frame");
  a_sclk_half_per: assert property ($rose(sclk) |-> sclk [*4] ##1 !sclk)
    else $error("sclk high phase wrong");
  a_sdi_hold_high: assert property (sclk |-> $stable(sdi))
    else $error("sdi moved while sclk high");
  a_sdo_on_low: assert property ($changed(sdo) |-> !sclk)
    else $error("sdo moved while sclk high");
  a_busy_has_wel: assert property (busy_out |-> write_enable_latch_out)
    else $error("busy without write enable");
  a_busy_after_cs: assert property ($rose(busy_out) |-> cs_n && $past(cs_n, 2))
    else $error("busy rose inside frame");
  a_busy_end_wel: assert property ($fell(busy_out) |-> $fell(write_enable_latch_out))
    else $error("wel not cleared with busy");
  a_busy_length: assert property ($fell(busy_out) |-> (cnt_r == srep_pkg::SECREG_BYTES + ERASE_CYC)
                                  || (cnt_r == srep_pkg::SECREG_BYTES + PROG_CYC))
    else $error("busy length wrong");
  a_wel_set_idle: assert property ($rose(write_enable_latch_out) |-> !busy_out && cs_n)
    else $error("wel set while busy");
  c_busy_rise: cover property ($rose(busy_out));
  c_busy_fall: cover property ($fell(busy_out));
  c_sdo_move: cover property ($changed(sdo));
endmodule // srep_assertions

// *** srep_dev.sv ***
// Purpose: device end, three one-time-protectable security registers
// Assumes: link pins are asynchronous and pass two flip-flops
// Notes:   erase/program/write-enable/read-status only
//
// Behaviour
// - three independent 256-byte security registers
// - erase accepted only with write enable set
// - host sends 44h plus register-select address
// - host raises select after last address bit
// - erase discarded unless select rises on boundary
// - valid erase starts self-timed erase cycle
// - status read still answered while busy
// - busy held through cycle, other commands refused
// - erase completion clears write enable latch
// - locked register ignores erase
// - locked register ignores program
// - program writes one to 256 bytes
// - host programs only erased locations
// - program accepted only with write enable set
// - host sends 42h, address, data bytes
// - host holds select low whole program
// - erase refused in quad interface mode
// - program refused in quad interface mode
// - bits captured on serial clock rising edge
`timescale 1ns/10ps
module srep_dev #(
  parameter int ERASE_CYC = srep_pkg::SECREG_ERASE_CYC,
  parameter int PROG_CYC  = srep_pkg::SECREG_PROG_CYC
) (
  input  wire logic       clk_in,
  input  wire logic       srst_in,
  srep_link_if.dev        link,
  input  wire logic [2:0] secreg_lock_bits_in,
  input  wire logic       qpi_mode_in,
  input  wire logic [1:0] peek_sel_in,
  input  wire logic [7:0] peek_addr_in,
  output logic            busy_out,
  output logic            write_enable_latch_out,
  output logic [7:0]      peek_data_out
);
  import srep_pkg::*;

  // ===================================================
  // state
  typedef struct packed {
    logic [1:0]   cs_s;
    logic [1:0]   ck_s;
    logic [1:0]   di_s;
    logic         cs_d;
    logic         ck_d;
    logic [5:0]   cnt;
    logic [2:0]   dbit;
    logic         got;
    logic         rd_act;
    logic [2:0]   obit;
    logic [7:0]   sh;
    logic [7:0]   op;
    logic [23:0]  addr;
    logic [7:0]   ptr;
    logic         write_enable_latch;
    logic         busy;
    logic         is_prog;
    logic [1:0]   sel;
    logic [8:0]   step;
    logic [23:0]  timer;
    logic         sdo;
    logic [7:0]   peek;
    logic [255:0] mask;
  } srep_dev_s;

  srep_dev_s  r;
  srep_dev_s  n;
  logic [7:0] mem  [0:SECREG_NUM*SECREG_BYTES-1];
  logic [7:0] pbuf [0:SECREG_BYTES-1];
  logic       buf_we;
  logic       mem_we;
  logic [9:0] mem_wa;
  logic [7:0] mem_wd;
  logic [7:0] stat;
  logic [7:0] sh_n;
  logic       rise;
  logic       fall;
  logic       cs_fall;
  logic       cs_rise;
  logic       sel_on;
  logic       addr_ok;
  logic       locked;
  logic       hit;
  logic [23:0] lim;

  // ===================================================
  // next state
  always_comb begin
    n       = r;
    n.cs_s  = {r.cs_s[0], link.cs_n};
    n.ck_s  = {r.ck_s[0], link.sclk};
    n.di_s  = {r.di_s[0], link.sdi};
    n.cs_d  = r.cs_s[1];
    n.ck_d  = r.ck_s[1];
    rise    = r.ck_s[1] & ~r.ck_d;
    fall    = ~r.ck_s[1] & r.ck_d;
    cs_fall = ~r.cs_s[1] & r.cs_d;
    cs_rise = r.cs_s[1] & ~r.cs_d;
    sel_on  = ~r.cs_s[1];
    sh_n    = {r.sh[6:0], r.di_s[1]};
    stat    = 8'h00;
    stat[ST_BUSY_BIT] = r.busy;
    stat[ST_WEL_BIT]  = r.write_enable_latch;
    buf_we  = 1'b0;
    mem_we  = 1'b0;
    mem_wa  = {2'(r.sel - 2'h1), r.step[7:0]};
    mem_wd  = r.is_prog ? (mem[mem_wa] & pbuf[r.step[7:0]]) : 8'hFF;
    addr_ok = (r.addr[23:16] == 8'h00) && (r.addr[11:8] == 4'h0)
              && (r.addr[15:12] >= SEL_FIRST) && (r.addr[15:12] <= SEL_LAST);
    locked  = secreg_lock_bits_in[2'(r.addr[13:12] - 2'h1)];
    hit     = (r.cnt == 6'(HDR_BITS)) && (r.dbit == 3'h0) && r.write_enable_latch
              && !qpi_mode_in && addr_ok && !locked;
    lim     = r.is_prog ? 24'(PROG_CYC - 1) : 24'(ERASE_CYC - 1);
    n.peek  = mem[{peek_sel_in, peek_addr_in}];

    if (cs_fall) begin
      n.cnt    = 6'h00;
      n.dbit   = 3'h0;
      n.got    = 1'b0;
      n.rd_act = 1'b0;
      n.obit   = 3'h0;
      if (!r.busy) begin
        n.mask = '0;
      end
    end else if (sel_on && rise) begin
      n.sh = sh_n;
      if (r.cnt != 6'(HDR_BITS)) begin
        n.cnt = r.cnt + 6'h01;
        if (r.cnt == 6'(OPC_BITS - 1)) begin
          n.op     = sh_n;
          n.rd_act = (sh_n == OPC_RDSR);
        end else if (r.cnt >= 6'(OPC_BITS)) begin
          n.addr = {r.addr[22:0], r.di_s[1]};
          n.ptr  = {r.addr[6:0], r.di_s[1]};
        end
      end else begin
        n.dbit = r.dbit + 3'h1;
        if (r.dbit == 3'h7) begin
          n.got = 1'b1;
          n.ptr = r.ptr + 8'h01;
          if (r.op == OPC_PROG && !r.busy) begin
            buf_we         = 1'b1;
            n.mask[r.ptr]  = 1'b1;
          end
        end
      end
    end else if (sel_on && fall && r.rd_act) begin
      n.sdo  = stat[3'h7 - r.obit];
      n.obit = r.obit + 3'h1;
    end

    if (cs_rise && !r.busy) begin
      if (r.op == OPC_WREN && r.cnt == 6'(OPC_BITS)) begin
        n.write_enable_latch = 1'b1;
      end else if (hit && ((r.op == OPC_ERASE && !r.got) || (r.op == OPC_PROG && r.got))) begin
        n.busy    = 1'b1;
        n.is_prog = (r.op == OPC_PROG);
        n.sel     = r.addr[13:12];
        n.step    = 9'h000;
        n.timer   = 24'h000000;
      end
    end

    if (r.busy) begin
      if (!r.step[8]) begin
        mem_we = !r.is_prog || r.mask[r.step[7:0]];
        n.step = r.step + 9'h001;
      end else if (r.timer == lim) begin
        n.busy = 1'b0;
        n.write_enable_latch  = 1'b0;
      end else begin
        n.timer = r.timer + 24'h000001;
      end
    end
  end

  // ===================================================
  // registers and storage
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      r       <= '0;
      r.cs_s  <= 2'b11;
      r.cs_d  <= 1'b1;
    end else begin
      r <= n;
    end
  end

  always_ff @(posedge clk_in) begin
    if (buf_we) begin
      pbuf[r.ptr] <= sh_n;
    end
    if (mem_we) begin
      mem[mem_wa] <= mem_wd;
    end
  end

  assign link.sdo               = r.sdo;
  assign busy_out               = r.busy;
  assign write_enable_latch_out = r.write_enable_latch;
  assign peek_data_out          = r.peek;
endmodule // srep_dev

// *** srep_host.sv ***
// Purpose: host end, issues write enable, status read, erase and program frames
// Assumes: sdo from the device is asynchronous and passes two flip-flops
// Notes:   serial clock made here by dividing clk_in
`timescale 1ns/10ps
module srep_host (
  input  wire logic              clk_in,
  input  wire logic              srst_in,
  srep_link_if.host              link,
  input  wire logic              req_valid_in,
  input  srep_pkg::srep_op_e     req_op_in,
  input  wire logic [23:0]       req_addr_in,
  input  wire logic [8:0]        req_len_in,
  output logic                   req_ready_out,
  input  wire logic              data_valid_in,
  input  wire logic [7:0]        data_in,
  output logic                   data_ready_out,
  output logic                   stat_valid_out,
  output logic [7:0]             stat_out
);
  import srep_pkg::*;

  // ===================================================
  // state
  typedef enum logic [2:0] {H_IDLE, H_SHIFT, H_DATA, H_END, H_GAP} srep_hst_e;

  typedef struct packed {
    srep_hst_e   st;
    logic [7:0]  div;
    logic        sclk;
    logic        cs_n;
    logic        sdi;
    logic [31:0] sh;
    logic [11:0] nbit;
    logic [11:0] total;
    logic        is_prog;
    logic        is_rd;
    logic [7:0]  rx;
    logic [1:0]  sdo_s;
    logic        ready;
    logic        dready;
    logic        stat_v;
    logic [7:0]  stat;
  } srep_hst_s;

  srep_hst_s   r;
  srep_hst_s   n;
  logic        tick;
  logic [11:0] nxt;
  logic [7:0]  opc;

  // ===================================================
  // next state
  always_comb begin
    n        = r;
    n.sdo_s  = {r.sdo_s[0], link.sdo};
    n.stat_v = 1'b0;
    tick     = (r.div == 8'(SCLK_HALF_CYC - 1));
    nxt      = r.nbit + 12'h001;
    unique case (req_op_in)
      SREP_WREN:  opc = OPC_WREN;
      SREP_RDSR:  opc = OPC_RDSR;
      SREP_ERASE: opc = OPC_ERASE;
      SREP_PROG:  opc = OPC_PROG;
    endcase
    if (r.st != H_IDLE && r.st != H_DATA) begin
      n.div = tick ? 8'h00 : r.div + 8'h01;
    end
    unique case (r.st)
      H_IDLE: begin
        n.ready = 1'b1;
        if (req_valid_in && r.ready) begin
          n.ready   = 1'b0;
          n.cs_n    = 1'b0;
          n.div     = 8'h00;
          n.nbit    = 12'h000;
          n.is_prog = (req_op_in == SREP_PROG);
          n.is_rd   = (req_op_in == SREP_RDSR);
          n.sh      = {opc, req_addr_in};
          n.sdi     = opc[7];
          unique case (req_op_in)
            SREP_WREN:  n.total = 12'(OPC_BITS);
            SREP_RDSR:  n.total = 12'(2 * OPC_BITS);
            SREP_ERASE: n.total = 12'(HDR_BITS);
            SREP_PROG:  n.total = 12'(HDR_BITS) + {req_len_in, 3'b000};
          endcase
          n.st = H_SHIFT;
        end
      end
      H_SHIFT: begin
        if (tick) begin
          if (!r.sclk) begin
            n.sclk = 1'b1;
          end else begin
            n.sclk = 1'b0;
            // sample late: device answer plus two synchroniser stages outlast a half period
            if (r.is_rd && r.nbit >= 12'(OPC_BITS)) begin
              n.rx = {r.rx[6:0], r.sdo_s[1]};
            end
            if (nxt == r.total) begin
              n.st = H_END;
            end else begin
              n.nbit = nxt;
              if (r.is_prog && nxt >= 12'(HDR_BITS) && nxt[2:0] == 3'h0) begin
                n.st     = H_DATA;
                n.dready = 1'b1;
              end else begin
                n.sh  = {r.sh[30:0], 1'b0};
                n.sdi = r.sh[30];
              end
            end
          end
        end
      end
      H_DATA: begin
        if (data_valid_in && r.dready) begin
          n.dready = 1'b0;
          n.sh     = {data_in, 24'h000000};
          n.sdi    = data_in[7];
          n.div    = 8'h00;
          n.st     = H_SHIFT;
        end
      end
      H_END: begin
        if (tick) begin
          n.cs_n = 1'b1;
          n.st   = H_GAP;
          if (r.is_rd) begin
            n.stat_v = 1'b1;
            n.stat   = r.rx;
          end
        end
      end
      H_GAP: begin
        if (tick) begin
          n.st    = H_IDLE;
          n.ready = 1'b1;
        end
      end
    endcase
  end

  // ===================================================
  // registers
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      r      <= '0;
      r.cs_n <= 1'b1;
      r.st   <= H_IDLE;
    end else begin
      r <= n;
    end
  end

  assign link.cs_n      = r.cs_n;
  assign link.sclk      = r.sclk;
  assign link.sdi       = r.sdi;
  assign req_ready_out  = r.ready;
  assign data_ready_out = r.dready;
  assign stat_valid_out = r.stat_v;
  assign stat_out       = r.stat;
endmodule // srep_host

// *** srep_link_if.sv ***
// Purpose: serial link between the host end and the device end
// Assumes: all signals point-to-point, no shared wires
// Notes:   sclk idles low, sdi sampled on the rising edge, sdo sampled by the host on the falling edge
`timescale 1ns/10ps
interface srep_link_if;
  logic cs_n;
  logic sclk;
  logic sdi;
  logic sdo;
  modport dev  (input cs_n, input sclk, input sdi, output sdo);
  modport host (output cs_n, output sclk, output sdi, input sdo);
endinterface

// *** srep_pkg.sv ***
// Purpose: shared constants and types for the security register erase/program link
// Assumes: 40 MHz system clock, serial clock made by the host end
// Notes:   all cycle counts derive from the times below
package srep_pkg;
  // ===================================================
  // opcodes
  localparam logic [7:0] OPC_WREN  = 8'h06;
  localparam logic [7:0] OPC_RDSR  = 8'h05;
  localparam logic [7:0] OPC_ERASE = 8'h44;
  localparam logic [7:0] OPC_PROG  = 8'h42;
  // ===================================================
  // frame layout and status bits
  localparam int OPC_BITS     = 8;
  localparam int HDR_BITS     = 32;
  localparam int SECREG_BYTES = 256;
  localparam int SECREG_NUM   = 3;
  localparam int ST_BUSY_BIT  = 0;
  localparam int ST_WEL_BIT   = 1;
  localparam logic [3:0] SEL_FIRST = 4'h1;
  localparam logic [3:0] SEL_LAST  = 4'h3;
  // ===================================================
  // timing
  localparam int CLK_PERIOD_NS        = 25;
  localparam int SCLK_PERIOD_NS       = 200;
  localparam int SCLK_HALF_CYC        = SCLK_PERIOD_NS / (2 * CLK_PERIOD_NS);
  localparam int SECREG_ERASE_TIME_US = 300;
  localparam int SECREG_ERASE_CYC     = (SECREG_ERASE_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SECREG_PROG_TIME_US  = 800;
  localparam int SECREG_PROG_CYC      = (SECREG_PROG_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // ===================================================
  // host request kinds
  typedef enum logic [1:0] {SREP_WREN, SREP_RDSR, SREP_ERASE, SREP_PROG} srep_op_e;
endpackage

// *** tb_top.sv ***
// Purpose: bench for host and device ends
// Assumes: short erase/program counts
// Notes: second device driven bit by bit
`timescale 1ns/10ps
module tb_top;
  import srep_pkg::*;
  localparam int E_CYC = 20;
  localparam int P_CYC = 600;
  logic clk_in = 0, srst_in = 1, rv = 0, dv = 0, qpi = 0, rrdy, drdy, sv, busy, write_enable_latch, busy2, wel2;
  srep_op_e rop = SREP_WREN;
  logic [23:0] raddr = 0;
  logic [8:0] rlen = 0;
  logic [7:0] din = 0, so, pdat, paddr = 0, m [3][256];
  logic [2:0] lock = 0;
  logic [1:0] psel = 0;
  logic wel_m = 0, busy_m = 0;
  int unsigned seed = 93;
  int num_errors = 0, compares = 0;
  int sv_cnt = 0, rd_cnt = 0;
  always @(posedge clk_in) if (sv === 1'b1) sv_cnt++;
  always #12.5 clk_in = ~clk_in;
  srep_link_if link_i ();
  srep_link_if link2_i ();
  srep_dev #(.ERASE_CYC(E_CYC), .PROG_CYC(P_CYC)) srep_dev_i (.clk_in(clk_in), .srst_in(srst_in),
    .link(link_i), .secreg_lock_bits_in(lock), .qpi_mode_in(qpi), .peek_sel_in(psel), .peek_addr_in(paddr),
    .busy_out(busy), .write_enable_latch_out(write_enable_latch), .peek_data_out(pdat));
  srep_dev #(.ERASE_CYC(E_CYC), .PROG_CYC(P_CYC)) srep_dev_x_i (.clk_in(clk_in), .srst_in(srst_in),
    .link(link2_i), .secreg_lock_bits_in(3'h0), .qpi_mode_in(1'b0), .peek_sel_in(2'h0), .peek_addr_in(8'h00),
    .busy_out(busy2), .write_enable_latch_out(wel2), .peek_data_out());
  srep_host srep_host_i (.clk_in(clk_in), .srst_in(srst_in), .link(link_i), .req_valid_in(rv), .req_op_in(rop),
    .req_addr_in(raddr), .req_len_in(rlen), .req_ready_out(rrdy), .data_valid_in(dv), .data_in(din),
    .data_ready_out(drdy), .stat_valid_out(sv), .stat_out(so));
  srep_assertions #(.ERASE_CYC(E_CYC), .PROG_CYC(P_CYC)) srep_assertions_i (.clk_in(clk_in), .srst_in(srst_in),
    .cs_n(link_i.cs_n), .sclk(link_i.sclk), .sdi(link_i.sdi), .sdo(link_i.sdo), .busy_out(busy),
    .write_enable_latch_out(write_enable_latch));
  // ====
  // helpers
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  task automatic close_out();
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("Error %s exp %h got %h", s, e, g);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task automatic wt(ref logic s);
    int n;
    n = 0;
    while (s !== 1'b1 && n < 20000) begin
      tick(1);
      n++;
    end
    if (n == 20000) begin
      num_errors++;
      close_out();
    end
  endtask
  task automatic req(input srep_op_e op, input logic [23:0] a, input int len);
    logic [3:0] sel;
    logic ok;
    logic [7:0] d;
    sel = a[15:12];
    ok = wel_m && !busy_m && !qpi && a[23:16] == 0 && a[11:8] == 0 && sel >= 1 && sel <= 3 && !lock[sel - 4'h1];
    wt(rrdy);
    rv = 1;
    rop = op;
    raddr = a;
    rlen = len[8:0];
    if (op == SREP_RDSR) rd_cnt++;
    tick(1);
    rv = 0;
    tick(1);
    for (int i = 0; i < len; i++) begin
      wt(drdy);
      d = rnd();
      dv = 1;
      din = d;
      if (ok) m[sel - 1][a[7:0] + i[7:0]] &= d;
      tick(1);
      dv = 0;
      tick(1);
    end
    if (op == SREP_WREN && !busy_m) wel_m = 1;
    if (op == SREP_ERASE && ok) for (int j = 0; j < 256; j++) m[sel - 1][j] = 8'hFF;
    if (ok && (op == SREP_ERASE || op == SREP_PROG && len > 0)) busy_m = 1;
    tick(2);
    wt(rrdy);
  endtask
  task automatic poll(input logic exp_busy);
    int n;
    n = 0;
    req(SREP_RDSR, 0, 0);
    chk("first busy", {7'h0, exp_busy}, {7'h0, so[0]});
    while (so[0] === 1'b1 && n < 100) begin
      req(SREP_RDSR, 0, 0);
      n++;
    end
    if (so[0] !== 1'b0) begin
      num_errors++;
      close_out();
    end
    if (busy_m) wel_m = 0;
    busy_m = 0;
    chk("status", {6'h0, wel_m, 1'b0}, so);
    chk("wel pin", {7'h0, wel_m}, {7'h0, write_enable_latch});
    chk("busy pin", 8'h00, {7'h0, busy});
    chk("stat pulses", rd_cnt[7:0], sv_cnt[7:0]);
  endtask
  task automatic chk_all();
    for (int r = 0; r < 3; r++) for (int j = 0; j < 256; j++) begin
      psel = r[1:0];
      paddr = j[7:0];
      tick(2);
      chk("mem", m[r][j], pdat);
    end
  endtask
  task automatic bb(input logic [39:0] v, input int n);
    link2_i.cs_n = 0;
    for (int i = 0; i < n; i++) begin
      link2_i.sdi = v[39 - i];
      tick(4);
      link2_i.sclk = 1;
      tick(4);
      link2_i.sclk = 0;
    end
    tick(4);
    link2_i.cs_n = 1;
    link2_i.sdi = ~link2_i.sdi;
    tick(8);
  endtask
  // ====
  // sequence
  initial begin
    link2_i.cs_n = 1;
    link2_i.sclk = 0;
    link2_i.sdi = 0;
    tick(20);
    srst_in = 0;
    for (int r = 1; r <= 3; r++) begin
      req(SREP_WREN, 0, 0);
      req(SREP_ERASE, {8'h00, r[3:0], 4'h0, rnd()}, 0);
      poll(1);
    end
    chk_all();
    req(SREP_WREN, 0, 0);
    req(SREP_PROG, 24'h0010F0, 20);
    poll(1);
    req(SREP_WREN, 0, 0);
    req(SREP_PROG, 24'h002000, 256);
    poll(1);
    req(SREP_PROG, 24'h003000, 1);
    req(SREP_ERASE, 24'h002000, 0);
    poll(0);
    req(SREP_WREN, 0, 0);
    req(SREP_ERASE, 24'h012000, 0);
    req(SREP_ERASE, 24'h002100, 0);
    req(SREP_ERASE, 24'h004000, 0);
    qpi = 1;
    req(SREP_ERASE, 24'h002000, 0);
    req(SREP_PROG, 24'h003000, 2);
    qpi = 0;
    lock = 3'h4;
    req(SREP_ERASE, 24'h003000, 0);
    req(SREP_PROG, 24'h003010, 3);
    poll(0);
    req(SREP_PROG, 24'h001005, 2);
    req(SREP_ERASE, 24'h002000, 0);
    poll(1);
    chk_all();
    bb({8'h06, 32'h0}, 8);
    chk("wel two", 8'h01, {7'h0, wel2});
    bb({8'h44, 32'h00100000}, 33);
    bb({8'h44, 32'h00100000}, 31);
    chk("short long", 8'h00, {7'h0, busy2});
    bb({8'h44, 32'h00100000}, 32);
    chk("good erase", 8'h01, {7'h0, busy2});
    close_out();
  end
endmodule // tb_top
